/* File: include/pfmx_defs.vh */
// constants for the port f low pin mux and port g direction block
`ifndef PFMX_DEFS_VH
`define PFMX_DEFS_VH

// register byte offsets
`define PFMX_OFF_FUNC_SEL 4'h0
`define PFMX_OFF_PG_DIR 4'h4
`define PFMX_OFF_PF_DIR 4'h8
`define PFMX_OFF_STATUS 4'hC

// register selector codes
`define PFMX_SEL_NONE 3'h0
`define PFMX_SEL_FUNC 3'h1
`define PFMX_SEL_PGDIR 3'h2
`define PFMX_SEL_PFDIR 3'h3
`define PFMX_SEL_STAT 3'h4

// reset values and writable masks
`define PFMX_FUNC_RESET 16'h5000
`define PFMX_FUNC_WMASK 16'h5D55
`define PFMX_PG_DIR_RESET 4'h0
`define PFMX_PF_DIR_RESET 8'h00

// field positions in the function select register
`define PFMX_BIT7_POS 14
`define PFMX_BIT6_POS 12
`define PFMX_BIT5_LO_POS 10

// operating modes
`define PFMX_MODE_EXP_NOROM 2'h0
`define PFMX_MODE_EXP_ROM 2'h1
`define PFMX_MODE_SINGLE 2'h2

// pin function codes
`define PFMX_FN_GPIO 2'h0
`define PFMX_FN_ADDR 2'h1
`define PFMX_FN_STROBE 2'h2
`define PFMX_FN_POD 2'h3

// bus responses
`define PFMX_RESP_OKAY 2'h0
`define PFMX_RESP_SLVERR 2'h2

`endif

/* File: src/pfmx_pin_decode.v */
// function decode for one port f low pin
`timescale 1ns/10ps
`default_nettype none
`include "pfmx_defs.vh"

module pfmx_pin_decode #(
   parameter PIN = 0
) (
   // operating mode and mode field
   input wire [1:0] op_mode,
   input wire [1:0] md,
   // decoded function
   output reg [1:0] fn
);

   wire expanded;

   assign expanded = (op_mode == `PFMX_MODE_EXP_NOROM) || (op_mode == `PFMX_MODE_EXP_ROM);

   always @*
   begin
      fn = `PFMX_FN_GPIO;
      if (PIN >= 6)
      begin
         if (expanded && md[0])
            fn = `PFMX_FN_STROBE;
      end
      else if (PIN == 5)
      begin
         case (op_mode)
            `PFMX_MODE_EXP_NOROM:
            begin
               if (md != 2'h3)
                  fn = `PFMX_FN_ADDR;
            end
            `PFMX_MODE_EXP_ROM:
            begin
               if (md == 2'h1)
                  fn = `PFMX_FN_ADDR;
               else if (md == 2'h2)
                  fn = `PFMX_FN_POD;
            end
            default:
            begin
               if (md == 2'h2)
                  fn = `PFMX_FN_POD;
            end
         endcase
      end
      else
      begin
         case (op_mode)
            `PFMX_MODE_EXP_NOROM: fn = `PFMX_FN_ADDR;
            `PFMX_MODE_EXP_ROM: fn = md[0] ? `PFMX_FN_ADDR : `PFMX_FN_GPIO;
            default: fn = `PFMX_FN_GPIO;
         endcase
      end
   end

endmodule
`default_nettype wire

/* File: src/pfmx_axil_slave.v */
// axi4-lite slave front end, one write and one read at a time
`timescale 1ns/10ps
`default_nettype none
`include "pfmx_defs.vh"

module pfmx_axil_slave (
   // clock and reset
   input wire aclk,
   input wire aresetn,
   // write address and data
   input wire [3:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   // write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // read address and data
   input wire [3:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // register file side
   output wire wr_en,
   output reg [3:0] wr_addr,
   output reg [31:0] wr_data,
   output reg [3:0] wr_strb,
   input wire wr_ok,
   output wire rd_en,
   input wire [31:0] rd_data,
   input wire rd_ok
);

   reg aw_have_reg;
   reg w_have_reg;
   wire aw_take;
   wire w_take;
   wire aw_have_next;
   wire w_have_next;
   wire bvalid_next;
   wire rvalid_next;

   assign aw_take = s_axi_awvalid & s_axi_awready;
   assign w_take = s_axi_wvalid & s_axi_wready;
   // write happens once both halves are held, in whichever order they came
   assign wr_en = aw_have_reg & w_have_reg & ~s_axi_bvalid;
   assign aw_have_next = aw_take | (aw_have_reg & ~wr_en);
   assign w_have_next = w_take | (w_have_reg & ~wr_en);
   assign bvalid_next = wr_en | (s_axi_bvalid & ~s_axi_bready);
   assign rd_en = s_axi_arvalid & s_axi_arready;
   assign rvalid_next = rd_en | (s_axi_rvalid & ~s_axi_rready);

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_have_reg <= 1'b0;
         w_have_reg <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `PFMX_RESP_OKAY;
         wr_addr <= 4'h0;
         wr_data <= 32'h00000000;
         wr_strb <= 4'h0;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `PFMX_RESP_OKAY;
      end
      else
      begin
         aw_have_reg <= aw_have_next;
         w_have_reg <= w_have_next;
         s_axi_awready <= ~aw_have_next & ~bvalid_next;
         s_axi_wready <= ~w_have_next & ~bvalid_next;
         s_axi_bvalid <= bvalid_next;
         if (aw_take)
            wr_addr <= s_axi_awaddr;
         if (w_take)
         begin
            wr_data <= s_axi_wdata;
            wr_strb <= s_axi_wstrb;
         end
         if (wr_en)
            s_axi_bresp <= wr_ok ? `PFMX_RESP_OKAY : `PFMX_RESP_SLVERR;
         s_axi_arready <= ~rvalid_next;
         s_axi_rvalid <= rvalid_next;
         if (rd_en)
         begin
            s_axi_rdata <= rd_ok ? rd_data : 32'h00000000;
            s_axi_rresp <= rd_ok ? `PFMX_RESP_OKAY : `PFMX_RESP_SLVERR;
         end
      end
   end

endmodule
`default_nettype wire

/* File: src/pfmx_top.v */
// port f low function select, port f/g direction and pin mux
//
// The AXI4-Lite slave port and the address map were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "pfmx_defs.vh"

module pfmx_top (
   // clock and reset
   input wire aclk,
   input wire aresetn,
   // reset cause and standby
   input wire reset_by_watchdog,
   input wire hw_standby,
   // operating mode pins
   input wire [1:0] mode_pins,
   // axi4-lite write address and data
   input wire [3:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   // axi4-lite write response
   output wire [1:0] s_axi_bresp,
   output wire s_axi_bvalid,
   input wire s_axi_bready,
   // axi4-lite read
   input wire [3:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output wire [31:0] s_axi_rdata,
   output wire [1:0] s_axi_rresp,
   output wire s_axi_rvalid,
   input wire s_axi_rready,
   // on-chip sources for port f pins
   input wire [7:0] pf_out_data,
   input wire [5:0] ext_addr_hi,
   input wire upper_write_strobe,
   input wire lower_write_strobe,
   // port f pins
   input wire [7:0] pf_pin_in,
   output reg [7:0] pf_pin_out,
   output reg [7:0] pf_pin_oe_n,
   // port f results
   output reg [7:0] pf_gpio_in,
   output reg port_output_disable_in_n,
   // port g
   input wire [3:0] pg_gpio_sel,
   input wire [3:0] pg_out_data,
   input wire [3:0] pg_pin_in,
   output reg [3:0] pg_pin_out,
   output reg [3:0] pg_pin_oe_n,
   output reg [3:0] pg_gpio_in
);

   // register state
   reg [15:0] port_f_low_function_select_reg;
   reg [3:0] port_g_direction_reg;
   reg [7:0] port_f_direction_reg;
   reg [1:0] op_mode_reg;
   wire [15:0] port_f_low_function_select_next;
   wire [3:0] port_g_direction_next;
   wire [7:0] port_f_direction_next;
   wire clear_regs;

   // bus side
   wire wr_en;
   wire [3:0] wr_addr;
   wire [31:0] wr_data;
   wire [3:0] wr_strb;
   wire rd_en;
   reg [31:0] rd_data;
   wire [2:0] wr_sel;
   wire [2:0] rd_sel;
   wire wr_ok;
   wire rd_ok;

   // decoded functions
   wire [15:0] pin_fn;
   wire [7:0] pf_out_next;
   wire [7:0] pf_oe_n_next;

   function [2:0] reg_select;
      input [3:0] addr;
      begin
         case (addr)
            `PFMX_OFF_FUNC_SEL: reg_select = `PFMX_SEL_FUNC;
            `PFMX_OFF_PG_DIR: reg_select = `PFMX_SEL_PGDIR;
            `PFMX_OFF_PF_DIR: reg_select = `PFMX_SEL_PFDIR;
            `PFMX_OFF_STATUS: reg_select = `PFMX_SEL_STAT;
            default: reg_select = `PFMX_SEL_NONE;
         endcase
      end
   endfunction

   function [15:0] merge_lanes;
      input [15:0] old_val;
      input [15:0] new_val;
      input [1:0] strb;
      begin
         merge_lanes[7:0] = strb[0] ? new_val[7:0] : old_val[7:0];
         merge_lanes[15:8] = strb[1] ? new_val[15:8] : old_val[15:8];
      end
   endfunction

   pfmx_axil_slave u_bus (
      .aclk(aclk),
      .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .wr_en(wr_en),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .wr_strb(wr_strb),
      .wr_ok(wr_ok),
      .rd_en(rd_en),
      .rd_data(rd_data),
      .rd_ok(rd_ok)
   );

   assign wr_sel = reg_select(wr_addr);
   assign rd_sel = reg_select(s_axi_araddr);
   // status is read-only, so a write to it is refused
   assign wr_ok = (wr_sel != `PFMX_SEL_NONE) && (wr_sel != `PFMX_SEL_STAT);
   assign rd_ok = (rd_sel != `PFMX_SEL_NONE);

   // reserved bits never store, so they always read zero
   assign port_f_low_function_select_next = merge_lanes(port_f_low_function_select_reg,
      wr_data[15:0], wr_strb[1:0]) & `PFMX_FUNC_WMASK;
   assign port_g_direction_next = wr_strb[0] ? wr_data[3:0] : port_g_direction_reg;
   assign port_f_direction_next = wr_strb[0] ? wr_data[7:0] : port_f_direction_reg;

   // a watchdog-caused reset leaves the settings alone; standby always clears
   assign clear_regs = (~aresetn & ~reset_by_watchdog) | hw_standby;

   always @(posedge aclk)
   begin
      if (clear_regs)
      begin
         port_f_low_function_select_reg <= `PFMX_FUNC_RESET;
         port_g_direction_reg <= `PFMX_PG_DIR_RESET;
         port_f_direction_reg <= `PFMX_PF_DIR_RESET;
      end
      else if (wr_en && aresetn)
      begin
         if (wr_sel == `PFMX_SEL_FUNC)
            port_f_low_function_select_reg <= port_f_low_function_select_next;
         if (wr_sel == `PFMX_SEL_PGDIR)
            port_g_direction_reg <= port_g_direction_next;
         if (wr_sel == `PFMX_SEL_PFDIR)
            port_f_direction_reg <= port_f_direction_next;
      end
   end

   // mode pins are static; they are caught while reset is held
   always @(posedge aclk)
   begin
      if (!aresetn)
         op_mode_reg <= mode_pins;
   end

   always @*
   begin
      rd_data = 32'h00000000;
      case (rd_sel)
         `PFMX_SEL_FUNC: rd_data[15:0] = port_f_low_function_select_reg;
         `PFMX_SEL_PGDIR: rd_data[3:0] = port_g_direction_reg;
         `PFMX_SEL_PFDIR: rd_data[7:0] = port_f_direction_reg;
         `PFMX_SEL_STAT:
         begin
            rd_data[1:0] = op_mode_reg;
            rd_data[23:8] = pin_fn;
         end
         default: rd_data = 32'h00000000;
      endcase
   end

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1)
      begin : g_pf
         wire [1:0] md;
         wire [1:0] fn;
         wire addr_bit;
         wire strobe_bit;
         // one driver per bit: each lane keeps its own variables
         reg out_bit;
         reg oe_n_bit;

         if (gi == 5)
         begin : g_wide
            assign md = port_f_low_function_select_reg[`PFMX_BIT5_LO_POS + 1:`PFMX_BIT5_LO_POS];
         end
         else
         begin : g_narrow
            assign md = {1'b0, port_f_low_function_select_reg[2 * gi]};
         end

         if (gi < 6)
         begin : g_addr
            assign addr_bit = ext_addr_hi[gi];
            assign strobe_bit = 1'b1;
         end
         else
         begin : g_strobe
            assign addr_bit = 1'b0;
            assign strobe_bit = (gi == 7) ? upper_write_strobe : lower_write_strobe;
         end

         pfmx_pin_decode #(
            .PIN(gi)
         ) u_dec (
            .op_mode(op_mode_reg),
            .md(md),
            .fn(fn)
         );

         assign pin_fn[2 * gi + 1:2 * gi] = fn;

         always @*
         begin
            case (fn)
               `PFMX_FN_ADDR:
               begin
                  out_bit = addr_bit;
                  oe_n_bit = 1'b0;
               end
               `PFMX_FN_STROBE:
               begin
                  out_bit = strobe_bit;
                  oe_n_bit = 1'b0;
               end
               `PFMX_FN_POD:
               begin
                  out_bit = 1'b0;
                  oe_n_bit = 1'b1;
               end
               default:
               begin
                  out_bit = pf_out_data[gi];
                  oe_n_bit = ~port_f_direction_reg[gi];
               end
            endcase
         end

         assign pf_out_next[gi] = out_bit;
         assign pf_oe_n_next[gi] = oe_n_bit;
      end
   endgenerate

   // pins are registered: one cycle from a source change to the pad
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pf_pin_out <= 8'h00;
         pf_pin_oe_n <= 8'hFF;
         pf_gpio_in <= 8'h00;
         port_output_disable_in_n <= 1'b1;
         pg_pin_out <= 4'h0;
         pg_pin_oe_n <= 4'hF;
         pg_gpio_in <= 4'h0;
      end
      else
      begin
         pf_pin_out <= pf_out_next;
         pf_pin_oe_n <= pf_oe_n_next;
         pf_gpio_in <= pf_pin_in;
         // the disable input idles inactive when pin 5 has another use
         if (pin_fn[11:10] == `PFMX_FN_POD)
            port_output_disable_in_n <= pf_pin_in[5];
         else
            port_output_disable_in_n <= 1'b1;
         pg_pin_out <= pg_out_data;
         // a pin given to another function never drives from here
         pg_pin_oe_n <= ~(port_g_direction_reg & pg_gpio_sel);
         pg_gpio_in <= pg_pin_in;
      end
   end

endmodule
`default_nettype wire

/* File: testbench/pfmx_chk.sv */
// concurrent checks on the port f low pin mux block ports
`timescale 1ns/10ps
`default_nettype none
module pfmx_checker (
   // clock and reset
   input wire aclk,
   input wire aresetn,
   // register bus
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [3:0] s_axi_araddr,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   // pins
   input wire [7:0] pf_pin_in,
   input wire [7:0] pf_pin_oe_n,
   input wire [7:0] pf_gpio_in,
   input wire port_output_disable_in_n,
   input wire [3:0] pg_out_data,
   input wire [3:0] pg_pin_in,
   input wire [3:0] pg_pin_out,
   input wire [3:0] pg_gpio_in
);
   // read address kept so read data can be judged per register
   reg [3:0] ra_reg;
   always @(posedge aclk)
   begin
      if (!aresetn)
         ra_reg <= 4'h0;
      else if (s_axi_arvalid && s_axi_arready)
         ra_reg <= s_axi_araddr;
   end
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   a_write_answer: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
      else $error("write response missing");
   a_read_answer: assert property (rd_taken |=> s_axi_rvalid)
      else $error("read response missing");
   a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   a_reserved_zero: assert property (
      s_axi_rvalid && ra_reg == 4'h0 |-> (s_axi_rdata & 32'hFFFFA2AA) == 32'h0)
      else $error("reserved select bit set");
   a_pgdir_upper: assert property (
      s_axi_rvalid && ra_reg == 4'h4 |-> (s_axi_rdata & 32'hFFFFFFF0) == 32'h0)
      else $error("port g direction upper bits set");
   a_pin_delay: assert property ($past(aresetn) |-> pg_pin_out == $past(pg_out_data)
      && pf_gpio_in == $past(pf_pin_in) && pg_gpio_in == $past(pg_pin_in))
      else $error("pin path not one cycle");
   a_disable_follow: assert property (
      !port_output_disable_in_n |-> pf_pin_oe_n[5] && !$past(pf_pin_in[5]))
      else $error("disable input not from pin");
   a_reset_idle: assert property (disable iff (1'b0)
      !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && pf_pin_oe_n == 8'hFF)
      else $error("outputs not idle after reset");
endmodule
bind pfmx_top pfmx_checker pfmx_checker_inst (.*);
`default_nettype wire

/* File: testbench/tb_port_f_low_pin_mux_port_g_dir.sv */
// self-checking bench for the port f low pin mux block
`timescale 1ns/10ps
`default_nettype none
module tb_port_f_low_pin_mux_port_g_dir;
   reg aclk = 0, aresetn = 0, rbw = 0, hws = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
   reg uws = 0, lws = 0;
   reg [1:0] mp = 0;
   reg [3:0] awa = 0, ws = 0, ara = 0, pgs = 0, pgo = 0, pgi = 0;
   reg [31:0] wd = 0;
   reg [7:0] pfo = 0, pfi = 0;
   reg [5:0] eah = 0;
   wire awr, wr, bv, arr, rv, podn;
   wire [1:0] brs, rrs;
   wire [31:0] rdt;
   wire [7:0] pfpo, pfoe, pfgi;
   wire [3:0] pgpo, pgoe, pggi;
   integer fails = 0, check_count = 0;
   always #5 aclk = ~aclk;
   pfmx_top pfmx_top_inst (.aclk(aclk), .aresetn(aresetn), .reset_by_watchdog(rbw),
      .hw_standby(hws), .mode_pins(mp), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
      .s_axi_wready(wr), .s_axi_bresp(brs), .s_axi_bvalid(bv), .s_axi_bready(br),
      .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdt),
      .s_axi_rresp(rrs), .s_axi_rvalid(rv), .s_axi_rready(rr), .pf_out_data(pfo),
      .ext_addr_hi(eah), .upper_write_strobe(uws), .lower_write_strobe(lws),
      .pf_pin_in(pfi), .pf_pin_out(pfpo), .pf_pin_oe_n(pfoe), .pf_gpio_in(pfgi),
      .port_output_disable_in_n(podn), .pg_gpio_sel(pgs), .pg_out_data(pgo),
      .pg_pin_in(pgi), .pg_pin_out(pgpo), .pg_pin_oe_n(pgoe), .pg_gpio_in(pggi));
   task chk(input string n, input [31:0] s, input [31:0] e);
      begin
         check_count = check_count + 1;
         if (s !== e)
         begin
            fails = fails + 1;
            $display("Error %s expected %h seen %h", n, e, s);
         end
      end
   endtask
   task close_out;
      begin
         $display("checks %0d mismatches %0d", check_count, fails);
         if (fails == 0 && check_count > 0)
            $display("== PASSED ==");
         else
            $display("== FAILED ==");
         $finish;
      end
   endtask
   task rst(input [1:0] m, input w);
      begin
         @(posedge aclk);
         mp <= m;
         rbw <= w;
         aresetn <= 0;
         repeat (4) @(posedge aclk);
         aresetn <= 1;
      end
   endtask
   // address and data offered together, each dropped once taken
   // waits for the answer however long it takes; only the watchdog ends a hang
   task axw(input [3:0] a, input [31:0] d, output [1:0] r);
      begin
         @(posedge aclk);
         awa <= a;
         wd <= d;
         ws <= 4'hF;
         awv <= 1;
         wv <= 1;
         br <= 1;
         do
         begin
            @(posedge aclk);
            if (awr)
               awv <= 0;
            if (wr)
               wv <= 0;
         end while (bv !== 1'b1);
         r = brs;
         br <= 0;
      end
   endtask
   task axr(input [3:0] a, output [31:0] d, output [1:0] r);
      begin
         @(posedge aclk);
         ara <= a;
         arv <= 1;
         rr <= 1;
         do
         begin
            @(posedge aclk);
            if (arr)
               arv <= 0;
         end while (rv !== 1'b1);
         d = rdt;
         r = rrs;
         rr <= 0;
      end
   endtask
   // model: 0 gpio, 1 address, 2 strobe, 3 disable input
   function [1:0] fnm(input integer m, input [15:0] f, input integer p);
      begin
         if (p > 5)
            fnm = (m != 2 && f[2*p]) ? 2'h2 : 2'h0;
         else if (p < 5)
            fnm = (m == 0 || (m == 1 && f[2*p])) ? 2'h1 : 2'h0;
         else if (f[11:10] == 2'h3)
            fnm = 2'h0;
         else if (m == 0)
            fnm = 2'h1;
         else if (f[11:10] == 2'h2)
            fnm = 2'h3;
         else
            fnm = (m == 1 && f[10]) ? 2'h1 : 2'h0;
      end
   endfunction
   task pins(input integer m, input [15:0] f, input [7:0] d, input [3:0] g);
      integer i;
      reg [1:0] fn, rs;
      reg [15:0] fs;
      reg [7:0] eoe, eout;
      reg [31:0] rd;
      reg ep;
      begin
         pfo <= $urandom;
         pfi <= $urandom;
         eah <= $urandom;
         uws <= $urandom;
         lws <= $urandom;
         pgs <= $urandom;
         pgo <= $urandom;
         pgi <= $urandom;
         axr(4'hC, rd, rs);
         #1;
         ep = 1;
         for (i = 0; i < 8; i = i + 1)
         begin
            fn = fnm(m, f, i);
            fs[2*i +: 2] = fn;
            eoe[i] = (fn == 0) ? ~d[i] : (fn == 3);
            eout[i] = fn == 0 ? pfo[i] : fn == 1 ? eah[i] : fn == 2 ? (i == 7 ? uws : lws) : 1'b0;
            if (fn == 3)
               ep = pfi[5];
         end
         chk("status", rd & 32'h00FFFF03, {8'h0, fs, 6'h0, m[1:0]});
         chk("status_rresp", rs, 32'h0);
         chk("pf_oe_n", pfoe, eoe);
         chk("pf_out", pfpo, eout);
         chk("disable_n", podn, ep);
         chk("pg_oe_n", pgoe, {28'h0, ~(g & pgs)});
         chk("pg_out", pgpo, pgo);
         chk("pg_in", pggi, pgi);
         chk("pf_in", pfgi, pfi);
      end
   endtask
   initial
   begin
      #400000;
      fails = fails + 1;
      close_out;
   end
   initial
   begin : main
      integer m, k;
      reg [31:0] v, f, d;
      reg [1:0] r;
      void'($urandom(32'hC57FDB3C));
      for (m = 0; m < 3; m = m + 1)
      begin
         rst(m, 0);
         axr(4'h0, v, r);
         chk("func_reset", v, 32'h5000);
         axr(4'h4, v, r);
         chk("pgdir_reset", v, 32'h0);
         axr(4'h8, v, r);
         chk("pfdir_reset", v, 32'h0);
         pins(m, 16'h5000, 8'h0, 4'h0);
         for (k = 0; k < 8; k = k + 1)
         begin
            f = ($urandom & 32'hFFFFF3FF) | ((k % 4) << 10);
            d = $urandom;
            axw(4'h0, f, r);
            chk("func_resp", r, 32'h0);
            axw(4'h8, d, r);
            axw(4'h4, d >> 8, r);
            axr(4'h0, v, r);
            chk("func_read", v, f & 32'h5D55);
            chk("func_rresp", r, 32'h0);
            axr(4'h4, v, r);
            chk("pgdir_read", v, (d >> 8) & 32'hF);
            pins(m, f[15:0], d[7:0], d[11:8]);
         end
      end
      axw(4'hC, 32'hFFFF, r);
      chk("status_write", r, 32'h2);
      axr(4'h2, v, r);
      chk("bad_rd_resp", r, 32'h2);
      chk("bad_rd_data", v, 32'h0);
      axw(4'h4, 32'hA, r);
      rst(2'h1, 1'b1);
      axr(4'h4, v, r);
      chk("pgdir_keep", v, 32'hA);
      axr(4'h0, v, r);
      chk("func_keep", v, f & 32'h5D55);
      hws <= 1;
      @(posedge aclk);
      hws <= 0;
      axr(4'h0, v, r);
      chk("func_standby", v, 32'h5000);
      axr(4'h4, v, r);
      chk("pgdir_standby", v, 32'h0);
      close_out;
   end
endmodule
`default_nettype wire
